// [logic/ahd_map.svh]
/*
  Offsets, field positions, codes, identifiers and timing counts for the
  acknowledge header and memory-read framer.
  Assumes it is included by bare name and sits beside ahd_pkg.
*/
`ifndef AHD_MAP_SVH
`define AHD_MAP_SVH

// ==========================================================
// Acknowledge header byte offsets
`define AHD_ACK_OFS_RESULT 0
`define AHD_ACK_OFS_OPCODE 2
`define AHD_ACK_OFS_LEN 4
`define AHD_ACK_OFS_TAG 6
`define AHD_HDR_BYTES 8

// ==========================================================
// Command header and memory-read payload
`define AHD_CMD_OFS_FLAGS 0
`define AHD_FLAG_WANT_ANSWER 14
`define AHD_RD_OFS_ADDR 0
`define AHD_RD_OFS_RSVD 8
`define AHD_RD_OFS_COUNT 10
`define AHD_RD_PAYLOAD_BYTES 16'h000c
`define AHD_CMD_TOTAL_BYTES 5'h14

// ==========================================================
// Result word layout
`define AHD_RES_CODE_LSB 0
`define AHD_RES_CODE_W 12
`define AHD_RES_RSVD_BIT 12
`define AHD_RES_NS_LSB 13
`define AHD_RES_SEV_BIT 15

// ==========================================================
// Result codes
`define AHD_RESULT_OK 16'h0000
`define AHD_ERR_UNSUPPORTED_CMD 16'h8001
`define AHD_ERR_BAD_PARAM 16'h8002
`define AHD_ERR_NO_SUCH_ADDR 16'h8003
`define AHD_ERR_READ_ONLY 16'h8004
`define AHD_ERR_MISALIGNED 16'h8005
`define AHD_ERR_ACCESS_REFUSED 16'h8006
`define AHD_ERR_RECEIVER_OCCUPIED 16'h8007
`define AHD_ERR_ACK_TIMEOUT 16'h800b
`define AHD_ERR_BAD_HEADER 16'h800e
`define AHD_ERR_CONFIG_FORBIDS 16'h800f
`define AHD_ERR_GENERIC 16'h8fff

// ==========================================================
// Opcode identifiers
`define AHD_MEM_READ_REQUEST 16'h0800
`define AHD_MEM_READ_ANSWER 16'h0801
`define AHD_MEM_WRITE_REQUEST 16'h0802
`define AHD_MEM_WRITE_ANSWER 16'h0803
`define AHD_DEFERRED_ANSWER 16'h0805
`define AHD_EVENT_NOTICE 16'h0c00
`define AHD_EVENT_ANSWER 16'h0c01
`define AHD_VENDOR_ID_BIT 15

// ==========================================================
// Timing
`define AHD_CLK_MHZ 125
`define AHD_ACK_TIMEOUT_US 1000

`endif

// [logic/ahd_pkg.sv]
/*
  Types shared by the memory-read host: controller states and the
  decoded result word.
  Assumes ahd_map.svh is available for the constants.
*/
package ahd_pkg;

  typedef enum logic [2:0] {
    AHD_ST_IDLE = 3'b000,
    AHD_ST_SEND = 3'b001,
    AHD_ST_WAIT = 3'b010,
    AHD_ST_DATA = 3'b011,
    AHD_ST_DONE = 3'b100
  } ahd_state_e;

  typedef enum logic [1:0] {
    AHD_NS_STANDARD = 2'b00,
    AHD_NS_TRANSPORT = 2'b01,
    AHD_NS_DEVICE = 2'b10
  } ahd_ns_e;

  typedef logic [63:0] ahd_addr_t;
  typedef logic [15:0] ahd_word_t;

endpackage

// [logic/ahd_if.sv]
/*
  Carrier between the controller, the command serialiser and the
  acknowledge parser.
  Assumes all three run on one clock.
*/
interface ahd_if;
  import ahd_pkg::*;

  logic tx_start;
  ahd_word_t tx_flags;
  ahd_word_t tx_opcode;
  ahd_word_t tx_tag;
  ahd_word_t tx_count;
  ahd_addr_t tx_addr;
  logic tx_busy;

  logic rx_clear;
  logic hdr_valid;
  ahd_word_t hdr_result;
  ahd_word_t hdr_opcode;
  ahd_word_t hdr_len;
  ahd_word_t hdr_tag;
  logic data_valid;
  logic [7:0] data_byte;
  logic pkt_end;

  modport ctl (
    output tx_start, tx_flags, tx_opcode, tx_tag, tx_count, tx_addr, rx_clear,
    input tx_busy, hdr_valid, hdr_result, hdr_opcode, hdr_len, hdr_tag, data_valid, data_byte, pkt_end
  );
  modport tx (
    input tx_start, tx_flags, tx_opcode, tx_tag, tx_count, tx_addr,
    output tx_busy
  );
  modport rx (
    input rx_clear,
    output hdr_valid, hdr_result, hdr_opcode, hdr_len, hdr_tag, data_valid, data_byte, pkt_end
  );
endinterface

// [logic/ahd_cmd_tx.sv]
/*
  Serialises one memory-read command (common header then payload) onto
  the byte link, least significant byte of every field first.
  Assumes the controller holds the fields stable while tx_busy is high.
*/
`include "ahd_map.svh"
module ahd_cmd_tx (
  input wire logic clk,
  input wire logic rst_b,
  ahd_if.tx bus,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready
);
  import ahd_pkg::*;

  typedef struct packed {
    logic busy;
    logic [4:0] idx;
    logic valid;
    logic [7:0] data;
  } ahd_tx_s;

  ahd_tx_s s_q;
  ahd_tx_s s_d;

  // ==========================================================
  // Packet image
  function automatic logic [7:0] pkt_byte(input logic [4:0] idx);
    logic [159:0] img;
    img = {bus.tx_count, 16'h0000, bus.tx_addr, bus.tx_tag, `AHD_RD_PAYLOAD_BYTES,
           bus.tx_opcode, bus.tx_flags};
    pkt_byte = img[{idx, 3'b000} +: 8];
  endfunction

  // ==========================================================
  // Sequencer
  always_comb begin
    s_d = s_q;
    if (!s_q.busy && bus.tx_start) begin
      s_d.busy = 1'b1;
      s_d.idx = 5'h00;
      s_d.valid = 1'b1;
      s_d.data = pkt_byte(5'h00);
    end else if (s_q.busy && s_q.valid && tx_ready) begin
      if (s_q.idx == `AHD_CMD_TOTAL_BYTES - 5'h01) begin
        s_d.busy = 1'b0;
        s_d.valid = 1'b0;
      end else begin
        s_d.idx = s_q.idx + 5'h01;
        s_d.data = pkt_byte(s_q.idx + 5'h01);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.tx_busy = s_q.busy;
  assign tx_byte = s_q.data;
  assign tx_valid = s_q.valid;
endmodule

// [logic/ahd_ack_rx.sv]
/*
  Parses incoming answers: eight header bytes, least significant first,
  then as many payload bytes as the length field says.
  Assumes the transport has already removed any prefix and postfix.
*/
`include "ahd_map.svh"
module ahd_ack_rx (
  input wire logic clk,
  input wire logic rst_b,
  ahd_if.rx bus,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid
);
  import ahd_pkg::*;

  typedef struct packed {
    logic [16:0] cnt;
    logic [63:0] hdr;
    logic hdr_valid;
    logic data_valid;
    logic [7:0] data;
    logic pkt_end;
  } ahd_rx_s;

  ahd_rx_s s_q;
  ahd_rx_s s_d;

  function automatic ahd_word_t field16(input logic [63:0] hdr, input int ofs);
    field16 = hdr[ofs * 8 +: 16];
  endfunction

  // ==========================================================
  // Byte counter and field capture
  always_comb begin
    s_d = s_q;
    s_d.hdr_valid = 1'b0;
    s_d.data_valid = 1'b0;
    s_d.pkt_end = 1'b0;
    if (bus.rx_clear) begin
      s_d.cnt = '0;
    end else if (rx_valid) begin
      if (s_q.cnt < 17'(`AHD_HDR_BYTES)) begin
        s_d.hdr = {rx_byte, s_q.hdr[63:8]};
        s_d.cnt = s_q.cnt + 17'h00001;
        if (s_q.cnt == 17'(`AHD_HDR_BYTES - 1)) begin
          s_d.hdr_valid = 1'b1;
          if (field16(s_d.hdr, `AHD_ACK_OFS_LEN) == 16'h0000) begin
            s_d.pkt_end = 1'b1;
            s_d.cnt = '0;
          end
        end
      end else begin
        s_d.data_valid = 1'b1;
        s_d.data = rx_byte;
        s_d.cnt = s_q.cnt + 17'h00001;
        if (s_q.cnt == {1'b0, field16(s_q.hdr, `AHD_ACK_OFS_LEN)} + 17'(`AHD_HDR_BYTES - 1)) begin
          s_d.pkt_end = 1'b1;
          s_d.cnt = '0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.hdr_valid = s_q.hdr_valid;
  assign bus.hdr_result = field16(s_q.hdr, `AHD_ACK_OFS_RESULT);
  assign bus.hdr_opcode = field16(s_q.hdr, `AHD_ACK_OFS_OPCODE);
  assign bus.hdr_len = field16(s_q.hdr, `AHD_ACK_OFS_LEN);
  assign bus.hdr_tag = field16(s_q.hdr, `AHD_ACK_OFS_TAG);
  assign bus.data_valid = s_q.data_valid;
  assign bus.data_byte = s_q.data;
  assign bus.pkt_end = s_q.pkt_end;
endmodule

// [logic/ahd_mem_reader.sv]
/*
  Host-side memory-read controller: takes read orders, sends the command,
  waits for the answer, checks and decodes its header and passes the data.
  Assumes a byte link that adds and strips transport framing itself.
*/
`include "ahd_map.svh"
module ahd_mem_reader #(
  parameter int unsigned ACK_TIMEOUT_CYC = `AHD_ACK_TIMEOUT_US * `AHD_CLK_MHZ,
  parameter int unsigned ALIGN_BYTES = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  output logic req_ready,
  input wire ahd_pkg::ahd_addr_t req_addr,
  input wire ahd_pkg::ahd_word_t req_count,
  input wire logic req_want_answer,
  output logic done,
  output ahd_pkg::ahd_word_t result_word,
  output logic result_err,
  output ahd_pkg::ahd_ns_e result_ns,
  output logic [11:0] result_code,
  output logic result_known,
  output logic short_read,
  output logic rd_valid,
  output logic [7:0] rd_byte,
  output ahd_pkg::ahd_word_t rd_total,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid
);
  import ahd_pkg::*;

  // ==========================================================
  // Parameter checks
  if (ACK_TIMEOUT_CYC < 2) begin : g_bad_tmo
    $error("ack timeout must be at least two cycles");
  end
  if (ALIGN_BYTES == 0 || (ALIGN_BYTES & (ALIGN_BYTES - 1)) != 0) begin : g_bad_align
    $error("alignment must be a power of two");
  end

  typedef struct packed {
    ahd_state_e st;
    logic ready;
    ahd_word_t tag;
    ahd_word_t cmd_tag;
    ahd_addr_t addr;
    ahd_word_t count;
    logic want;
    logic start;
    logic clear;
    logic [31:0] tmo;
    ahd_word_t got;
    logic done;
    ahd_word_t result;
    logic known;
    logic short_rd;
    logic rd_valid;
    logic [7:0] rd_byte;
  } ahd_ctl_s;

  ahd_ctl_s s_q;
  ahd_ctl_s s_d;
  ahd_if bus ();

  ahd_cmd_tx u_tx (
    .clk(clk),
    .rst_b(rst_b),
    .bus(bus.tx),
    .tx_byte(tx_byte),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready)
  );

  ahd_ack_rx u_rx (
    .clk(clk),
    .rst_b(rst_b),
    .bus(bus.rx),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid)
  );

  // ==========================================================
  // Helpers
  function automatic logic misaligned(input ahd_addr_t a, input ahd_word_t c);
    misaligned = ((a & 64'(ALIGN_BYTES - 1)) != '0) || ((c & 16'(ALIGN_BYTES - 1)) != '0);
  endfunction

  function automatic logic std_known(input ahd_word_t r);
    case (r)
      `AHD_RESULT_OK, `AHD_ERR_UNSUPPORTED_CMD, `AHD_ERR_BAD_PARAM: std_known = 1'b1;
      `AHD_ERR_NO_SUCH_ADDR, `AHD_ERR_READ_ONLY, `AHD_ERR_ACCESS_REFUSED: std_known = 1'b1;
      `AHD_ERR_MISALIGNED, `AHD_ERR_RECEIVER_OCCUPIED: std_known = 1'b1;
      `AHD_ERR_ACK_TIMEOUT, `AHD_ERR_BAD_HEADER, `AHD_ERR_CONFIG_FORBIDS: std_known = 1'b1;
      `AHD_ERR_GENERIC: std_known = 1'b1;
      default: std_known = 1'b0;
    endcase
  endfunction

  function automatic logic vendor_id(input ahd_word_t id);
    vendor_id = id[`AHD_VENDOR_ID_BIT];
  endfunction

  // Ends a command with the given result word
  function automatic ahd_ctl_s finish(input ahd_ctl_s s, input ahd_word_t r);
    finish = s;
    finish.st = AHD_ST_DONE;
    finish.done = 1'b1;
    finish.result = r;
    finish.known = std_known(r);
  endfunction

  // ==========================================================
  // Controller
  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.clear = 1'b0;
    s_d.done = 1'b0;
    s_d.rd_valid = 1'b0;
    case (s_q.st)
      AHD_ST_IDLE: begin
        if (req_valid && s_q.ready) begin
          s_d.ready = 1'b0;
          s_d.addr = req_addr;
          s_d.count = req_count;
          s_d.want = req_want_answer;
          s_d.got = '0;
          s_d.short_rd = 1'b0;
          if (req_count == 16'h0000) begin
            s_d = finish(s_d, `AHD_ERR_BAD_PARAM);
          end else if (misaligned(req_addr, req_count)) begin
            s_d = finish(s_d, `AHD_ERR_MISALIGNED);
          end else begin
            s_d.cmd_tag = s_q.tag;
            s_d.tag = s_q.tag + 16'h0001;
            s_d.start = 1'b1;
            s_d.clear = 1'b1;
            s_d.st = AHD_ST_SEND;
          end
        end
      end
      AHD_ST_SEND: begin
        if (!s_q.start && !bus.tx_busy) begin
          s_d.tmo = '0;
          if (s_q.want) begin
            s_d.st = AHD_ST_WAIT;
          end else begin
            s_d = finish(s_d, `AHD_RESULT_OK);
          end
        end
      end
      AHD_ST_WAIT, AHD_ST_DATA: begin
        s_d.tmo = s_q.tmo + 32'h00000001;
        if (s_q.tmo == 32'(ACK_TIMEOUT_CYC - 1)) begin
          s_d = finish(s_d, `AHD_ERR_ACK_TIMEOUT);
        end else if (s_q.st == AHD_ST_WAIT && bus.hdr_valid && bus.hdr_tag == s_q.cmd_tag) begin
          if (bus.hdr_opcode == `AHD_DEFERRED_ANSWER) begin
            s_d.tmo = '0;
          end else if (bus.hdr_opcode != `AHD_MEM_READ_ANSWER || vendor_id(bus.hdr_opcode)) begin
            s_d = finish(s_d, `AHD_ERR_BAD_HEADER);
          end else if (bus.hdr_result[`AHD_RES_RSVD_BIT]) begin
            s_d = finish(s_d, `AHD_ERR_GENERIC);
          end else if (bus.hdr_len > s_q.count) begin
            s_d = finish(s_d, `AHD_ERR_BAD_HEADER);
          end else begin
            s_d.result = bus.hdr_result;
            s_d.known = std_known(bus.hdr_result);
            s_d.st = AHD_ST_DATA;
            if (bus.pkt_end) begin
              s_d.st = AHD_ST_DONE;
              s_d.done = 1'b1;
              s_d.short_rd = s_q.count != 16'h0000;
            end
          end
        end else if (s_q.st == AHD_ST_DATA && bus.data_valid) begin
          s_d.rd_valid = 1'b1;
          s_d.rd_byte = bus.data_byte;
          s_d.got = s_q.got + 16'h0001;
          if (bus.pkt_end) begin
            s_d.st = AHD_ST_DONE;
            s_d.done = 1'b1;
            s_d.short_rd = (s_q.got + 16'h0001) < s_q.count;
          end
        end
      end
      AHD_ST_DONE: begin
        s_d.ready = 1'b1;
        s_d.st = AHD_ST_IDLE;
      end
      default: begin
        s_d.st = AHD_ST_IDLE;
        s_d.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.st <= AHD_ST_IDLE;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Command fields and outputs
  assign bus.tx_start = s_q.start;
  assign bus.tx_flags = {1'b0, s_q.want, 14'h0000};
  assign bus.tx_opcode = `AHD_MEM_READ_REQUEST;
  assign bus.tx_tag = s_q.cmd_tag;
  assign bus.tx_addr = s_q.addr;
  assign bus.tx_count = s_q.count;
  assign bus.rx_clear = s_q.clear;

  assign req_ready = s_q.ready;
  assign done = s_q.done;
  assign result_word = s_q.result;
  assign result_err = s_q.result[`AHD_RES_SEV_BIT];
  assign result_ns = ahd_ns_e'(s_q.result[`AHD_RES_NS_LSB +: 2]);
  assign result_code = s_q.result[`AHD_RES_CODE_LSB +: `AHD_RES_CODE_W];
  assign result_known = s_q.known;
  assign short_read = s_q.short_rd;
  assign rd_valid = s_q.rd_valid;
  assign rd_byte = s_q.rd_byte;
  assign rd_total = s_q.got;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_accept;
    s_q.st == AHD_ST_IDLE && req_valid && s_q.ready;
  endsequence

  sequence s_send_end;
    s_q.st == AHD_ST_SEND && !s_q.start && !bus.tx_busy;
  endsequence

  a_flag_follows_want: assert property (tx_valid && u_tx.s_q.idx == 5'h01
    |-> tx_byte == {1'b0, s_q.want, 6'h00})
    else $error("want-answer flag does not follow the order");
  a_tag_bumps_once: assert property (s_accept ##0 (req_count != 0 && !misaligned(req_addr, req_count))
    |=> s_q.tag == $past(s_q.tag) + 16'h0001 && s_q.cmd_tag == $past(s_q.tag))
    else $error("sequence tag not advanced by one");
  a_zero_count_param: assert property (s_accept ##0 req_count == 0 |=> done && result_word == 16'h8002)
    else $error("zero count not refused");
  a_timeout_reports: assert property ((s_q.st == AHD_ST_WAIT || s_q.st == AHD_ST_DATA)
    && s_q.tmo == 32'(ACK_TIMEOUT_CYC - 1) |=> done && result_word == 16'h800b ##1 req_ready)
    else $error("timeout not reported");
  a_no_answer_ok: assert property (s_send_end ##0 !s_q.want |=> done && result_word == 16'h0000)
    else $error("unanswered read not closed with success");
  a_read_opcode: assert property (s_q.start |-> bus.tx_opcode == 16'h0800 ##1 bus.tx_busy)
    else $error("read request not sent with its opcode");
  a_short_flagged: assert property (done && s_q.rd_valid |-> short_read == (s_q.got < s_q.count))
    else $error("short read not flagged");
  a_result_reserved: assert property (done |-> !result_word[12] ##1 !done)
    else $error("reported result has reserved bit set");
  a_send_holds_busy: assert property (s_q.st == AHD_ST_SEND && bus.tx_busy |=> s_q.st == AHD_ST_SEND)
    else $error("send phase left while command bytes remain");
endmodule

// [tb/ahd_dev_model.sv]
/*
  Behavioural device at the far end of the byte link: collects one
  memory-read command and answers it as the bench orders.
  Assumes one clock shared with the host and 20-byte commands.
*/
module ahd_dev_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  input wire logic slow,
  input wire logic silent,
  input wire logic stray,
  input wire logic [15:0] ans_result,
  input wire logic [15:0] ans_opcode,
  input wire logic [15:0] ans_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cmd [20];
  int n;

  // ==========================================================
  // Answer framing
  task automatic send(input logic [7:0] b);
    // Gaps show a changing byte so a stale value cannot pass
    if (slow) repeat ($urandom_range(2, 0)) begin
      rx_valid <= 1'b0;
      rx_byte <= ~rx_byte;
      @(posedge clk);
    end
    rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge clk);
  endtask

  task automatic frame(input logic [15:0] tg, input logic [15:0] ln);
    logic [15:0] w [4];
    w = '{ans_result, ans_opcode, ln, tg};
    foreach (w[i]) begin
      send(w[i][7:0]);
      send(w[i][15:8]);
    end
    for (int i = 0; i < int'(ln); i++) send(cmd[8] + 8'(i));
  endtask

  // ==========================================================
  // Command intake
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    n = 0;
    forever begin
      @(posedge clk);
      if (!rst_b) n = 0;
      else if (tx_valid && tx_ready) begin
        cmd[n] = tx_byte;
        n++;
      end
      if (n == 20 && cmd[1][6] && !silent) begin
        n = 0;
        if (stray) frame({cmd[7], cmd[6]} + 16'h0001, 16'h0002);
        frame({cmd[7], cmd[6]}, ans_len);
        rx_valid <= 1'b0;
        rx_byte <= ~rx_byte;
      end else begin
        if (n == 20) n = 0;
        rx_valid <= 1'b0;
        rx_byte <= ~rx_byte;
        tx_ready <= slow ? 1'($urandom_range(1, 0)) : 1'b1;
      end
    end
  end
endmodule

// [tb/ahd_mem_reader_tb_top.sv]
/*
  Self-checking bench for the memory-read host controller.
  Assumes ahd_dev_model answers on the byte link.
*/
module ahd_mem_reader_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ahd_pkg::*;
  localparam int TO = 200;
  localparam logic [15:0] CODES [15] = '{16'h0000, 16'h8001, 16'h8002, 16'h8003,
    16'h8004, 16'h8005, 16'h8006, 16'h8007, 16'h800b, 16'h800e,
    16'h800f, 16'h8fff, 16'h0000, 16'h4123, 16'h2005};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic req_want_answer = 1'b0;
  ahd_addr_t req_addr = '0;
  ahd_word_t req_count = '0;
  logic req_ready, done, result_err, result_known, short_read, rd_valid, tx_valid, rx_valid;
  ahd_word_t result_word, rd_total;
  ahd_ns_e result_ns;
  logic [11:0] result_code;
  logic [7:0] rd_byte, tx_byte, rx_byte;
  logic tx_ready;
  logic slow = 1'b0;
  logic silent = 1'b0;
  logic stray = 1'b0;
  ahd_word_t m_res = '0;
  ahd_word_t m_op = '0;
  ahd_word_t m_len = '0;
  logic [7:0] tx_q [$];
  logic [7:0] rd_q [$];
  logic [33:0] res_q [$];
  ahd_word_t tag = '0;
  ahd_addr_t a;
  ahd_word_t c;
  int failures = 0;
  int cmp_count = 0;

  always #4 clk = ~clk;

  ahd_mem_reader #(.ACK_TIMEOUT_CYC(TO), .ALIGN_BYTES(4)) ahd_mem_reader_inst (.clk(clk), .rst_b(rst_b),
    .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr), .req_count(req_count),
    .req_want_answer(req_want_answer), .done(done), .result_word(result_word), .result_err(result_err),
    .result_ns(result_ns), .result_code(result_code), .result_known(result_known), .short_read(short_read),
    .rd_valid(rd_valid), .rd_byte(rd_byte), .rd_total(rd_total), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid));

  ahd_dev_model ahd_dev_model_inst (.clk(clk), .rst_b(rst_b), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid), .slow(slow), .silent(silent),
    .stray(stray), .ans_result(m_res), .ans_opcode(m_op), .ans_len(m_len));

  // ==========================================================
  // Comparison helpers
  task automatic check(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] e, input string m);
    check(got === e, m);
  endtask

  task automatic cmp_res(input logic [33:0] e);
    logic k;
    k = 1'b0;
    for (int i = 0; i < 12; i++) if (CODES[i] === e[15:0]) k = 1'b1;
    check(result_word === e[15:0] && result_err === e[15] && result_ns === e[14:13] && result_code === e[11:0]
      && result_known === k && (e[33] !== 1'b1 || {short_read, rd_total} === e[32:16]), "result");
  endtask

  task automatic conclude();
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // Output watcher
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) cmp_byte(tx_byte, tx_q.size() ? tx_q.pop_front() : 'x, "tx");
    if (rd_valid === 1'b1) cmp_byte(rd_byte, rd_q.size() ? rd_q.pop_front() : 'x, "rd");
    if (done === 1'b1) cmp_res(res_q.size() ? res_q.pop_front() : 'x);
  end

  // ==========================================================
  // One read order with its expected command, data and result
  task automatic order(input ahd_addr_t ad, input ahd_word_t cn, r, op, ln, input logic w, sil, str,
                       input ahd_word_t e, input int nd);
    logic [159:0] cmd;
    int t;
    slow <= 1'($urandom_range(1, 0));
    silent <= sil;
    stray <= str;
    m_res <= r;
    m_op <= op;
    m_len <= ln;
    req_valid <= 1'b1;
    req_addr <= ad;
    req_count <= cn;
    req_want_answer <= w;
    if (ad[1:0] == 2'b00 && cn[1:0] == 2'b00 && cn != 16'h0000) begin
      cmd = {cn, 16'h0000, ad, tag, 16'h000c, 16'h0800, 1'b0, w, 14'h0000};
      for (int i = 0; i < 20; i++) tx_q.push_back(cmd[8*i +: 8]);
      tag++;
    end
    for (int i = 0; i < nd; i++) rd_q.push_back(ad[7:0] + 8'(i));
    res_q.push_back({nd >= 0, nd < int'(cn), 16'(nd), e});
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    t = 0;
    while (done !== 1'b1) begin
      @(posedge clk);
      t++;
    end
    if (sil) check(t > TO + 20 && t < TO + 200, "timeout span");
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(32'h1dd078dd));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    order(64'h0000_1000_0000_0040, 16'h0008, 16'h0000, 16'h0801, 16'h0008, 1, 0, 0, 16'h0000, 8);
    repeat (6) begin
      a = {$urandom, $urandom} & ~64'h3;
      c = 16'(4 * $urandom_range(4, 1));
      order(a, c, 16'h0000, 16'h0801, c, 1, 0, 0, 16'h0000, int'(c));
    end
    foreach (CODES[i]) order(64'h20, 16'h0004, CODES[i], 16'h0801, 16'h0000, 1, 0, 0, CODES[i], 0);
    order(64'h44, 16'h000c, 16'h8003, 16'h0801, 16'h0004, 1, 0, 0, 16'h8003, 4);
    order(64'h48, 16'h0004, 16'h0000, 16'h0803, 16'h0000, 1, 0, 0, 16'h800e, -1);
    order(64'h4c, 16'h0004, 16'h0000, 16'h0c00, 16'h0000, 1, 0, 0, 16'h800e, -1);
    order(64'h4c, 16'h0004, 16'h0000, 16'h0805, 16'h0000, 1, 0, 0, 16'h800b, -1);
    order(64'h50, 16'h0004, 16'h9001, 16'h0801, 16'h0000, 1, 0, 0, 16'h8fff, -1);
    order(64'h54, 16'h0004, 16'h0000, 16'h0801, 16'h0004, 1, 0, 1, 16'h0000, 4);
    order(64'h58, 16'h0004, 16'h0000, 16'h0801, 16'h0004, 1, 1, 0, 16'h800b, -1);
    order(64'h5c, 16'h0004, 16'h0000, 16'h0801, 16'h0004, 0, 0, 0, 16'h0000, -1);
    order(64'h62, 16'h0004, 16'h0000, 16'h0801, 16'h0004, 1, 0, 0, 16'h8005, -1);
    order(64'h60, 16'h0000, 16'h0000, 16'h0801, 16'h0000, 1, 0, 0, 16'h8002, -1);
    order(64'h64, 16'h0004, 16'h0000, 16'h0801, 16'h0008, 1, 0, 0, 16'h800e, -1);
    repeat (4) @(posedge clk);
    conclude();
  end

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule
